// [tb/core_model.sv]
`timescale 1ns/1ns
module core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    arst_n,
  input  wire irq_ctrl_pkg::core_req_s core_req,
  input  wire logic [3:0]              cmd,
  input  wire logic                    slow,
  output irq_ctrl_pkg::core_evt_s      core_evt
);
  import irq_ctrl_pkg::*;
  logic [2:0] cnt_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg  <= 3'h0;
      core_evt <= '0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      // Instruction ends every 4 cycles, every 8 when slow
      core_evt.boundary <= slow ? &cnt_reg : &cnt_reg[1:0];
      // Routine start, slow core answers on odd counts only
      core_evt.ack <= core_req.req && !core_evt.ack
                      && (!slow || cnt_reg[0]);
      core_evt.return_from_irq_instr         <= cmd[0];
      core_evt.wait_enter   <= cmd[1];
      core_evt.stop_enter   <= cmd[2];
      core_evt.opt_wr_zero  <= cmd[3];
      core_evt.opt_wr_cycle <= 2'h1;
    end
  end
endmodule // core_model

// [tb/irq_ctrl_asserts.sv]
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module irq_ctrl_asserts
  import irq_ctrl_pkg::*;
(
  input wire logic                     mclk,
  input wire logic                     arst_n,
  input wire irq_ctrl_pkg::ahb_addr_s  ahb_a,
  input wire logic [31:0]              hrdata,
  input wire irq_ctrl_pkg::core_evt_s  core_evt,
  input wire irq_ctrl_pkg::core_req_s  core_req,
  input wire irq_ctrl_pkg::core_mode_e core_mode
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire req = core_req.req;

  a_req_hold: assert property (
    req && !core_evt.ack |=> req) else $error("request dropped early");
  a_ack_drop: assert property (
    req && core_evt.ack |=> !req) else $error("request kept after ack");
  a_nmi_entry: assert property (
    req && core_evt.ack && core_req.vec == `VEC_NMI
    |=> core_mode == MODE_NMI) else $error("no nmi mode on entry");
  a_irq_entry: assert property (
    req && core_evt.ack && core_req.vec != `VEC_NMI
    |=> core_mode == MODE_IRQ) else $error("no irq mode on entry");
  a_nmi_no_preempt: assert property (
    $stable(core_mode) && core_mode == MODE_NMI |-> !req)
    else $error("nmi routine preempted");
  a_irq_no_nest: assert property (
    $stable(core_mode) && core_mode == MODE_IRQ && req
    |-> core_req.vec == `VEC_NMI) else $error("maskable nesting");
  a_vec_range: assert property (
    req |-> core_req.vec <= `VEC_CONV) else $error("vector out of range");
  a_req_boundary: assert property (
    $rose(req) |-> $past(core_evt.boundary))
    else $error("request off boundary");
  a_keep_flags: assert property (
    $rose(req) && core_req.vec != `VEC_NMI && $past(core_evt.opt_wr_zero)
    && $past(core_evt.opt_wr_cycle) < 2'h3 |-> core_req.keep_normal_flags)
    else $error("normal flags not kept");
  a_opt_wo: assert property (
    $past(ahb_a.hsel && ahb_a.htrans[1] && !ahb_a.hwrite && ahb_a.hready
    && ahb_a.haddr == `IRQ_OPTION_OFFS) |-> hrdata == 32'h0)
    else $error("option register readable");
endmodule // irq_ctrl_asserts

// [tb/tb_irq_ctrl.sv]
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module tb_irq_ctrl;
  import irq_ctrl_pkg::*;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [1:0]  htr = 2'h0;
  logic [7:0]  hadr = 8'h00;
  logic        hwr = 1'b0;
  logic [31:0] hwd = 32'h0;
  logic [31:0] q;
  logic        nmi_n = 1'b1, pa_n = 1'b1, tmr = 1'b0, cnv = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  pb = 8'hff;
  logic [3:0]  cmd = 4'h0;
  int          num_errors = 0, compares = 0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, wake;
  ahb_addr_s   ahb_a;
  core_evt_s   core_evt;
  core_req_s   core_req;
  core_mode_e  core_mode;

  assign ahb_a = '{htr, hadr, hwr, 3'b010, htr[1], hreadyout};
  always #20 mclk = ~mclk;

  irq_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .ahb_a(ahb_a),
    .hwdata(hwd), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .nmi_pin_n(nmi_n), .porta_pin_n(pa_n), .portb_pins(pb),
    .timer_evt(tmr), .conv_evt(cnv), .core_evt(core_evt),
    .core_req(core_req), .core_mode(core_mode), .wake(wake));
  core_model core_u (.mclk(mclk), .arst_n(arst_n), .core_req(core_req),
    .cmd(cmd), .slow(slow), .core_evt(core_evt));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    htr  <= 2'b10;
    hadr <= a;
    hwr  <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htr <= 2'b00;
    hwd <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic pulse(input logic [2:0] c);
    @(posedge mclk);
    cmd[2:0] <= c;
    @(posedge mclk);
    cmd[2:0] <= 3'h0;
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wreq(input logic [2:0] v);
    repeat (40) begin
      @(negedge mclk);
      if (core_req.req === 1'b1) break;
    end
    chk({core_req.req, core_req.vec}, {1'b1, v});
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    tally_and_finish;
  end

  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    nx(1); chk(core_mode, MODE_NMI);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b0, 8'h00, 32'h0); chk(q, 32'h0);
    pulse(3'h1); nx(3); chk(core_mode, MODE_NORMAL);
    // Two falling edges on vector 1 while maskables are off
    repeat (2) begin
      @(posedge mclk) pa_n <= 1'b0;
      @(posedge mclk) pa_n <= 1'b1;
    end
    nx(12); chk(core_req.req, 1'b0);
    bus(1'b0, 8'h04, 32'h0); chk(q[5], 1'b1);
    bus(1'b1, 8'h00, 32'h10); wreq(`VEC_PA);
    nx(4); chk(core_mode, MODE_IRQ);
    bus(1'b0, 8'h04, 32'h0); chk(q[5], 1'b0);
    @(posedge mclk) tmr <= 1'b1;
    @(posedge mclk) tmr <= 1'b0;
    nx(12); chk(core_req.req, 1'b0);
    @(posedge mclk) nmi_n <= 1'b0;
    wreq(`VEC_NMI);
    @(posedge mclk) nmi_n <= 1'b1;
    nx(4); chk(core_mode, MODE_NMI);
    @(posedge mclk) nmi_n <= 1'b0;
    @(posedge mclk) nmi_n <= 1'b1;
    nx(12); chk(core_req.req, 1'b0);
    bus(1'b0, 8'h0c, 32'h0); chk(q[0], 1'b1);
    // Reset in mid routine
    @(posedge mclk) arst_n <= 1'b0;
    @(posedge mclk) arst_n <= 1'b1;
    nx(1); chk({core_mode, core_req.req}, {MODE_NMI, 1'b0});
    slow <= 1'b1;
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h10, 32'h1);
    pulse(3'h1);
    @(posedge mclk) pa_n <= 1'b0;
    @(posedge mclk) pb <= 8'hfe;
    @(posedge mclk) tmr <= 1'b1;
    @(posedge mclk) cnv <= 1'b1;
    @(posedge mclk) cnv <= 1'b0;
    tmr <= 1'b0;
    pa_n <= 1'b1;
    pb <= 8'hff;
    cmd[3] <= 1'b1;
    bus(1'b1, 8'h00, 32'h10);
    for (int v = 1; v <= 4; v++) begin
      wreq(v[2:0]);
      if (v == 1) chk(core_req.keep_normal_flags, 1'b1);
      nx(4);
      cmd[3] <= 1'b0;
      if (v > 2) bus(1'b1, 8'h0c, v - 2);
      pulse(3'h1);
    end
    bus(1'b0, 8'h0c, 32'h0); chk(q[1:0], 2'h0);
    pulse(3'h2); nx(2);
    bus(1'b0, 8'h04, 32'h0); chk(q[3:2], PWR_WAIT);
    @(posedge mclk) cnv <= 1'b1;
    @(posedge mclk) cnv <= 1'b0;
    wreq(`VEC_CONV);
    bus(1'b1, 8'h0c, 32'h2);
    pulse(3'h1);
    pulse(3'h4);
    @(posedge mclk) cnv <= 1'b1;
    @(posedge mclk) cnv <= 1'b0;
    nx(12);
    bus(1'b0, 8'h04, 32'h0); chk(q[3:2], PWR_STOP);
    nx(1); chk({wake, hresp}, 2'b00);
    @(posedge mclk) pa_n <= 1'b0;
    wreq(`VEC_PA);
    bus(1'b1, 8'h00, 32'h20);
    bus(1'b0, 8'h04, 32'h0); chk(q[6], 1'b1);
    tally_and_finish;
  end
endmodule // tb_irq_ctrl

bind irq_ctrl irq_ctrl_asserts chk_u (.mclk(mclk), .arst_n(arst_n),
  .ahb_a(ahb_a), .hrdata(hrdata), .core_evt(core_evt),
  .core_req(core_req), .core_mode(core_mode));

// [verilog/irq_ctrl.sv]
`timescale 1ns/1ns
`include "irq_ctrl_regs.svh"
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  input  wire irq_ctrl_pkg::ahb_addr_s       ahb_a,
  input  wire logic [31:0]                   hwdata,
  output logic [31:0]                        hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          nmi_pin_n,
  input  wire logic                          porta_pin_n,
  input  wire logic [`PB_PINS-1:0]           portb_pins,
  input  wire logic                          timer_evt,
  input  wire logic                          conv_evt,
  input  wire irq_ctrl_pkg::core_evt_s       core_evt,
  output irq_ctrl_pkg::core_req_s            core_req,
  output irq_ctrl_pkg::core_mode_e           core_mode,
  output logic                               wake
);
  import irq_ctrl_pkg::*;

  logic [7:0]            opt_reg;
  logic [1:0]            pen_reg;
  logic [1:0]            pflag_reg;
  logic [`PB_PINS-1:0]   pbcfg_reg;
  logic                  nmi_lat_reg;
  logic                  pa_lat_reg;
  logic                  pb_lat_reg;
  logic                  nmi_d_reg;
  logic                  pa_d_reg;
  logic                  pb_d_reg;
  logic                  stop_wake_ok_reg;
  core_mode_e            mode_reg;
  power_e                pwr_reg;
  core_req_s             req_reg;
  logic                  wr_pend_reg;
  logic                  rd_pend_reg;
  logic [7:0]            addr_reg;

  logic                  gen;
  logic                  ph_valid;
  logic                  wr_opt;
  logic                  wr_pbcfg;
  logic                  pb_line;
  logic                  pb_rise;
  logic                  pb_fall;
  logic                  pa_edge;
  logic                  pa_level;
  logic [4:1]            pend;
  logic [2:0]            win;
  logic                  grant_nmi;
  logic                  grant_mask;
  logic                  ack_vec;

  // Lowest-numbered pending vector wins
  function automatic logic [2:0] pick(input logic [4:1] p);
    logic [2:0] v;
    v = 3'h0;
    for (int i = 4; i >= 1; i--) begin
      if (p[i]) begin
        v = 3'(i);
      end
    end
    return v;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  assign gen = opt_reg[`GEN_BIT];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ph_valid = ahb_a.hsel && ahb_a.hready && ahb_a.htrans[1];
  assign wr_opt = wr_pend_reg && hit(addr_reg, `IRQ_OPTION_OFFS);
  assign wr_pbcfg = wr_pend_reg && hit(addr_reg, `IRQ_PORTB_CFG_OFFS);

  // Bus address phase capture
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= ph_valid && ahb_a.hwrite;
      rd_pend_reg <= ph_valid && !ahb_a.hwrite;
      if (ph_valid) begin
        addr_reg <= ahb_a.haddr;
      end
    end
  end

  // Write-only option register; reserved bits forced to zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      opt_reg <= `OPT_RESET;
    end else if (wr_opt) begin
      opt_reg <= hwdata[7:0] & `OPT_MASK;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pen_reg <= 2'h0;
      pbcfg_reg <= 8'h00;
    end else begin
      if (wr_pend_reg && hit(addr_reg, `IRQ_PERIPH_EN_OFFS)) begin
        pen_reg <= hwdata[1:0];
      end
      if (wr_pbcfg) begin
        pbcfg_reg <= hwdata[7:0];
      end
    end
  end

  // Peripheral flags: set wins over software write-one-to-clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pflag_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? timer_evt : conv_evt) begin
          pflag_reg[i] <= 1'b1;
        end else if (wr_pend_reg && hit(addr_reg, `IRQ_PERIPH_FLAG_OFFS)
                     && hwdata[i]) begin
          pflag_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ph_valid && !ahb_a.hwrite) begin
      case (ahb_a.haddr)
        `IRQ_STATUS_OFFS:
          hrdata <= {24'h0, 1'b0, pb_lat_reg, pa_lat_reg, nmi_lat_reg,
                     2'(pwr_reg), 2'(mode_reg)};
        `IRQ_PERIPH_EN_OFFS:   hrdata <= {30'h0, pen_reg};
        `IRQ_PERIPH_FLAG_OFFS: hrdata <= {30'h0, pflag_reg};
        `IRQ_PORTB_CFG_OFFS:   hrdata <= {24'h0, pbcfg_reg};
        default:               hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Vector 2 pins are combined before edge detection, so a pin held at
  // the low level masks edges on the others; pins in plain pull-up
  // mode read high.
  always_comb begin
    pb_line = 1'b1;
    for (int i = 0; i < `PB_PINS; i++) begin
      if (pbcfg_reg[i]) begin
        pb_line = pb_line & portb_pins[i];
      end
    end
  end

  assign pb_rise = pb_line && !pb_d_reg;
  assign pb_fall = !pb_line && pb_d_reg;
  assign pa_edge = !porta_pin_n ? pa_d_reg : 1'b0;
  assign pa_level = !porta_pin_n && opt_reg[`LS_BIT];
  assign ack_vec = core_evt.ack;

  // Line history, reset to the idle high level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_d_reg <= 1'b1;
      pa_d_reg <= 1'b1;
      pb_d_reg <= 1'b1;
    end else begin
      nmi_d_reg <= nmi_pin_n;
      pa_d_reg <= porta_pin_n;
      pb_d_reg <= pb_line;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_lat_reg <= 1'b0;
    end else if (nmi_d_reg && !nmi_pin_n) begin
      nmi_lat_reg <= 1'b1;
    end else if (ack_vec && core_req.vec == `VEC_NMI) begin
      nmi_lat_reg <= 1'b0;
    end
  end

  // One-deep edge latches; later edges just re-set an already set latch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pa_lat_reg <= 1'b0;
    end else if (pa_edge && !opt_reg[`LS_BIT]) begin
      pa_lat_reg <= 1'b1;
    end else if ((ack_vec && core_req.vec == `VEC_PA) || opt_reg[`LS_BIT]) begin
      pa_lat_reg <= 1'b0;
    end
  end

  // A flip to rising-edge polarity while the combined line is high, or a mode change on a low pin, acts as an edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pb_lat_reg <= 1'b0;
    end else if ((opt_reg[`ES_BIT] ? pb_rise : pb_fall)
                 || (wr_opt && hwdata[`ES_BIT] && !opt_reg[`ES_BIT]
                     && pb_line)
                 || (wr_pbcfg && (pbcfg_reg ^ hwdata[7:0]) != 8'h00
                     && ((pbcfg_reg ^ hwdata[7:0]) & ~portb_pins)
                        != 8'h00)) begin
      pb_lat_reg <= 1'b1;
    end else if (ack_vec && core_req.vec == `VEC_PB) begin
      pb_lat_reg <= 1'b0;
    end
  end

  // Pending maskables are latched whatever the global enable
  assign pend[1] = pa_lat_reg || pa_level;
  assign pend[2] = pb_lat_reg;
  assign pend[3] = pflag_reg[0] && pen_reg[0];
  assign pend[4] = pflag_reg[1] && pen_reg[1];
  assign win = pick(pend);
  assign grant_nmi = nmi_lat_reg && mode_reg != MODE_NMI;
  assign grant_mask = gen && pend != 4'h0
                      && mode_reg == MODE_NORMAL;

  // Request presented only at instruction boundaries, held until ack
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= '0;
    end else if (ack_vec) begin
      req_reg <= '0;
    end else if (core_evt.boundary && pwr_reg == PWR_RUN
                 && !req_reg.req) begin
      if (grant_nmi) begin
        req_reg <= '{req: 1'b1, vec: `VEC_NMI, keep_normal_flags: 1'b0};
      end else if (grant_mask) begin
        req_reg <= '{req: 1'b1, vec: win,
                     keep_normal_flags: core_evt.opt_wr_zero
                       && 3'(core_evt.opt_wr_cycle) < `OPT_WR_LATE};
      end
    end
  end

  assign core_req = req_reg;

  // Core flag mode; reset starts in NMI mode and aborts any routine
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= MODE_NMI;
    end else if (ack_vec) begin
      mode_reg <= (core_req.vec == `VEC_NMI) ? MODE_NMI
                                               : MODE_IRQ;
    end else if (core_evt.return_from_irq_instr) begin
      mode_reg <= MODE_NORMAL;
    end
  end

  assign core_mode = mode_reg;

  // Power state and wake-up
  always_comb begin
    wake = 1'b0;
    case (pwr_reg)
      PWR_WAIT: wake = (gen && (pend != 4'h0 || nmi_lat_reg));
      PWR_STOP: wake = gen && (nmi_lat_reg || pend[1] || pend[2]
                               || (pend[3] && stop_wake_ok_reg));
      default:  wake = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stop_wake_ok_reg <= 1'b1;
    end else begin
      stop_wake_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg <= PWR_RUN;
    end else begin
      case (pwr_reg)
        PWR_RUN: begin
          if (core_evt.stop_enter) begin
            pwr_reg <= PWR_STOP;
          end else if (core_evt.wait_enter) begin
            pwr_reg <= PWR_WAIT;
          end
        end
        PWR_WAIT, PWR_STOP: begin
          if (wake) begin
            pwr_reg <= PWR_RUN;
          end
        end
        default: pwr_reg <= PWR_RUN;
      endcase
    end
  end

endmodule  // irq_ctrl

// [verilog/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_IRQ,
    MODE_NMI
  } core_mode_e;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_WAIT,
    PWR_STOP
  } power_e;

  typedef struct packed {
    logic       req;
    logic [2:0] vec;
    logic       keep_normal_flags;
  } core_req_s;

  typedef struct packed {
    logic       boundary;
    logic       ack;
    logic       return_from_irq_instr;
    logic       wait_enter;
    logic       stop_enter;
    logic       opt_wr_zero;
    logic [1:0] opt_wr_cycle;
  } core_evt_s;

  typedef struct packed {
    logic [1:0] htrans;
    logic [7:0] haddr;
    logic       hwrite;
    logic [2:0] hsize;
    logic       hsel;
    logic       hready;
  } ahb_addr_s;

endpackage

// [verilog/irq_ctrl_regs.svh]
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// Register byte offsets
`define IRQ_OPTION_OFFS      8'h00
`define IRQ_STATUS_OFFS      8'h04
`define IRQ_PERIPH_EN_OFFS   8'h08
`define IRQ_PERIPH_FLAG_OFFS 8'h0c
`define IRQ_PORTB_CFG_OFFS   8'h10

// Option register fields
`define GEN_BIT    4
`define ES_BIT     5
`define LS_BIT     6
`define OPT_RESET  8'h00
`define OPT_MASK   8'h70

// Vector numbers
`define VEC_NMI    3'h0
`define VEC_PA     3'h1
`define VEC_PB     3'h2
`define VEC_TIMER  3'h3
`define VEC_CONV   3'h4

// Cycles of the option write instruction during which a request skips flags
`define OPT_WR_CYCLES   3'h4
`define OPT_WR_LATE     3'h3

`define PB_PINS    8

`endif
